//--- host_port_parallel_spi.sv
`default_nettype none
`include "host_port_regs.svh"

module host_port_parallel_spi #(
    parameter int IRQ_COUNT = 8
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // Mode straps
    input  wire logic                  serial_port_select,
    input  wire logic                  bus_style_select,
    // Parallel address and strobes
    input  wire logic                  address_top_line,
    input  wire logic [8:0]            address_low,
    input  wire logic                  chip_select_n,
    input  wire logic                  read_strobe_n,
    input  wire logic                  write_strobe_n,
    // Parallel data pins
    input  wire logic [`HP_DATA_W-1:0] data_in,
    output var  logic [`HP_DATA_W-1:0] data_out,
    output var  logic [`HP_DATA_W-1:0] data_oe_n,
    // Serial link
    input  wire logic                  serial_clock,
    input  wire logic                  serial_data_in,
    output var  logic                  serial_data_out,
    output var  logic                  serial_data_oe_n,
    // Interrupt
    input  wire logic [IRQ_COUNT-1:0]  irq_pending,
    input  wire logic [IRQ_COUNT-1:0]  irq_mask,
    output var  logic                  interrupt_out_n,
    output var  logic                  interrupt_oe_n,
    // Register file side
    output var  logic [`HP_ADDR_W-1:0] reg_addr,
    output var  logic [`HP_DATA_W-1:0] reg_wr_data,
    output var  logic                  reg_wr,
    output var  logic                  reg_rd,
    input  wire logic [`HP_DATA_W-1:0] reg_rd_data
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------

    if (IRQ_COUNT < 1) begin : g_bad_irq_count
        $error("IRQ_COUNT must be at least one");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------

    host_port_pkg::host_state_s st;
    host_port_pkg::host_state_s next_st;
    host_port_pkg::pins_s       pin_bundle;

    logic                  rst_meta_n;
    logic                  sys_rst_n;
    logic                  irq_drive;

    logic [`HP_ADDR_W-1:0] link_rd_addr;
    logic                  link_rd_toggle;
    logic [`HP_ADDR_W-1:0] link_wr_addr;
    logic [`HP_DATA_W-1:0] link_wr_data;
    logic                  link_wr_toggle;

    // Register index from the parallel address pins
    function automatic logic [`HP_ADDR_W-1:0] par_addr(
        input host_port_pkg::pins_s p
    );
        par_addr = {p.a_top, p.a_low};
    endfunction

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            sys_rst_n  <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            sys_rst_n  <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------
    // Serial link engine
    // ------------------------------------------------------------

    // Straps come from the synchronised data pins and are taken as static
    spi_link_engine u_link (
        .serial_clock     (serial_clock),
        .chip_select_n    (chip_select_n),
        .serial_data_in   (serial_data_in),
        .serial_data_out  (serial_data_out),
        .serial_data_oe_n (serial_data_oe_n),
        .clock_polarity   (st.now.d[7]),
        .clock_phase      (st.now.d[6]),
        .msb_first        (st.now.d[5]),
        .rst_n            (sys_rst_n),
        .rd_addr          (link_rd_addr),
        .rd_toggle        (link_rd_toggle),
        .wr_addr          (link_wr_addr),
        .wr_data          (link_wr_data),
        .wr_toggle        (link_wr_toggle),
        .rd_word          (st.spi_rd_word)
    );

    // ------------------------------------------------------------
    // Pin bundle
    // ------------------------------------------------------------

    always_comb begin
        pin_bundle            = '0;
        pin_bundle.port_sel   = serial_port_select;
        pin_bundle.style      = bus_style_select;
        pin_bundle.a_top      = address_top_line;
        pin_bundle.a_low      = address_low;
        pin_bundle.cs_n       = chip_select_n;
        pin_bundle.strobe_a_n = read_strobe_n;
        pin_bundle.strobe_b_n = write_strobe_n;
        pin_bundle.d          = data_in;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    always_comb begin
        host_port_pkg::pins_s p;
        host_port_pkg::pins_s q;
        logic rd_act;
        logic wr_edge;
        logic split;
        p       = st.now;
        q       = st.prev;
        next_st = st;
        rd_act  = 1'b0;
        wr_edge = 1'b0;
        split   = (p.style == `HP_STYLE_SPLIT);

        // Every bundled pin passes two flops; prev keeps one more for edges
        next_st.meta = pin_bundle;
        next_st.now  = st.meta;
        next_st.prev = st.now;

        next_st.rd_tgl_sync = {st.rd_tgl_sync[0], link_rd_toggle};
        next_st.wr_tgl_sync = {st.wr_tgl_sync[0], link_wr_toggle};

        next_st.reg_wr   = 1'b0;
        next_st.reg_rd   = 1'b0;
        next_st.irq_oe_n = ~irq_drive;

        if (split) begin
            rd_act  = !p.cs_n && !p.strobe_a_n;
            wr_edge = !q.strobe_b_n && p.strobe_b_n && !q.cs_n;
        end else begin
            rd_act  = !p.cs_n && !p.strobe_a_n && p.strobe_b_n;
            wr_edge = !q.strobe_a_n && p.strobe_a_n && !q.strobe_b_n && !q.cs_n;
        end

        if (p.port_sel == `HP_SEL_SPI) begin
            next_st.reading   = 1'b0;
            next_st.data_oe_n = '1;
            if (st.reg_rd) begin
                next_st.spi_rd_word = reg_rd_data;
            end
            // One request per cycle; a pending read waits a cycle behind a write
            if (st.wr_tgl_sync[1] != st.wr_tgl_seen) begin
                next_st.wr_tgl_seen = st.wr_tgl_sync[1];
                next_st.reg_addr    = link_wr_addr;
                next_st.reg_wr_data = link_wr_data;
                next_st.reg_wr      = 1'b1;
            end else if (st.rd_tgl_sync[1] != st.rd_tgl_seen) begin
                next_st.rd_tgl_seen = st.rd_tgl_sync[1];
                next_st.reg_addr    = link_rd_addr;
                next_st.reg_rd      = 1'b1;
            end
        end else begin
            // Keep seen in step so a later mode change replays nothing
            next_st.rd_tgl_seen = st.rd_tgl_sync[1];
            next_st.wr_tgl_seen = st.wr_tgl_sync[1];
            next_st.reading     = rd_act;
            if (rd_act) begin
                next_st.reg_addr = par_addr(p);
                next_st.reg_rd   = !st.reading;
            end
            // Drive only once the addressed data has come back
            if (rd_act && st.reading) begin
                next_st.data_out  = reg_rd_data;
                next_st.data_oe_n = '0;
            end else begin
                next_st.data_oe_n = '1;
            end
            if (wr_edge) begin
                next_st.reg_addr    = par_addr(q);
                next_st.reg_wr_data = q.d;
                next_st.reg_wr      = 1'b1;
            end
        end
    end

    assign irq_drive = |(irq_pending & ~irq_mask);

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------

    always_ff @(posedge sys_clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            st                 <= '0;
            st.meta.cs_n       <= 1'b1;
            st.meta.strobe_a_n <= 1'b1;
            st.meta.strobe_b_n <= 1'b1;
            st.now.cs_n        <= 1'b1;
            st.now.strobe_a_n  <= 1'b1;
            st.now.strobe_b_n  <= 1'b1;
            st.prev.cs_n       <= 1'b1;
            st.prev.strobe_a_n <= 1'b1;
            st.prev.strobe_b_n <= 1'b1;
            st.data_oe_n       <= '1;
            st.irq_oe_n        <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    assign data_out        = st.data_out;
    assign data_oe_n       = st.data_oe_n;
    assign reg_addr        = st.reg_addr;
    assign reg_wr_data     = st.reg_wr_data;
    assign reg_wr          = st.reg_wr;
    assign reg_rd          = st.reg_rd;
    // Open drain: the level is always low, the enable does the work
    assign interrupt_out_n = 1'b0;
    assign interrupt_oe_n  = st.irq_oe_n;

endmodule // host_port_parallel_spi

`default_nettype wire

//--- host_port_regs.svh
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// Register index and data widths
`define HP_ADDR_W      10
`define HP_DATA_W      8
`define HP_ADDR_ONE    10'h001

// Control word layout, 16 bits in stream order
`define HP_CTRL_RW     15
`define HP_CTRL_BURST  0
`define HP_RW_EARLY    14
`define HP_FIELD_W     14
`define HP_RW_READ     1'b1

// Bit counter marks
`define HP_ADDR_DONE   4'h0e
`define HP_CTRL_LAST   4'h0f
`define HP_DATA_LAST   4'h07
`define HP_PREFETCH_AT 4'h03

// Strap encodings
`define HP_STYLE_SPLIT 1'b0
`define HP_SEL_SPI     1'b1

`endif

//--- host_port_pkg.sv
`default_nettype none
`include "host_port_regs.svh"

package host_port_pkg;

    typedef enum logic [0:0] {
        SEQ_CTRL = 1'b0,
        SEQ_DATA = 1'b1
    } seq_phase_e;

    typedef struct packed {
        seq_phase_e              phase;
        logic [3:0]              bit_cnt;
        logic [14:0]             shift;
        logic                    is_read;
        logic                    burst;
        logic [`HP_ADDR_W-1:0]   addr;
    } link_seq_s;

    typedef struct packed {
        logic [`HP_ADDR_W-1:0]   rd_addr;
        logic                    rd_toggle;
        logic [`HP_ADDR_W-1:0]   wr_addr;
        logic [`HP_DATA_W-1:0]   wr_data;
        logic                    wr_toggle;
    } link_xfer_s;

    typedef struct packed {
        logic [6:0]              shift;
        logic                    out;
        logic                    oe_n;
    } link_tx_s;

    typedef struct packed {
        logic                    port_sel;
        logic                    style;
        logic                    a_top;
        logic [8:0]              a_low;
        logic                    cs_n;
        logic                    strobe_a_n;
        logic                    strobe_b_n;
        logic [`HP_DATA_W-1:0]   d;
    } pins_s;

    typedef struct packed {
        pins_s                   meta;
        pins_s                   now;
        pins_s                   prev;
        logic [1:0]              rd_tgl_sync;
        logic                    rd_tgl_seen;
        logic [1:0]              wr_tgl_sync;
        logic                    wr_tgl_seen;
        logic                    reading;
        logic [`HP_DATA_W-1:0]   spi_rd_word;
        logic [`HP_DATA_W-1:0]   data_out;
        logic [`HP_DATA_W-1:0]   data_oe_n;
        logic [`HP_ADDR_W-1:0]   reg_addr;
        logic [`HP_DATA_W-1:0]   reg_wr_data;
        logic                    reg_wr;
        logic                    reg_rd;
        logic                    irq_oe_n;
    } host_state_s;

    // Stream order to value: MSB first keeps, LSB first mirrors
    function automatic logic [13:0] order_field(input logic [13:0] f, input logic msb);
        for (int i = 0; i < 14; i++) begin
            order_field[i] = msb ? f[i] : f[13-i];
        end
    endfunction

    function automatic logic [7:0] order_byte(input logic [7:0] f, input logic msb);
        for (int i = 0; i < 8; i++) begin
            order_byte[i] = msb ? f[i] : f[7-i];
        end
    endfunction

endpackage

`default_nettype wire

//--- spi_link_engine.sv
`default_nettype none
`include "host_port_regs.svh"

module spi_link_engine (
    // Link pins
    input  wire logic                  serial_clock,
    input  wire logic                  chip_select_n,
    input  wire logic                  serial_data_in,
    output var  logic                  serial_data_out,
    output var  logic                  serial_data_oe_n,
    // Static straps and reset
    input  wire logic                  clock_polarity,
    input  wire logic                  clock_phase,
    input  wire logic                  msb_first,
    input  wire logic                  rst_n,
    // System side
    output var  logic [`HP_ADDR_W-1:0] rd_addr,
    output var  logic                  rd_toggle,
    output var  logic [`HP_ADDR_W-1:0] wr_addr,
    output var  logic [`HP_DATA_W-1:0] wr_data,
    output var  logic                  wr_toggle,
    input  wire logic [`HP_DATA_W-1:0] rd_word
);

    host_port_pkg::link_seq_s  seq, next_seq;
    host_port_pkg::link_xfer_s xfer, next_xfer;
    host_port_pkg::link_tx_s   tx, next_tx;
    logic                      sample_clk;
    logic                      seq_clear;

    // Mode 0 and 3 sample on rising, 1 and 2 on falling
    assign sample_clk = serial_clock ^ clock_polarity ^ clock_phase;
    // Sequencer restarts at the next frame; toggles must survive it
    assign seq_clear  = chip_select_n | ~rst_n;

    always_comb begin
        logic [15:0] word;
        logic [13:0] early;
        logic [13:0] field;
        word      = {seq.shift, serial_data_in};
        early     = host_port_pkg::order_field(word[13:0], msb_first);
        field     = host_port_pkg::order_field(word[14:1], msb_first);
        next_seq  = seq;
        next_xfer = xfer;
        next_seq.shift   = word[14:0];
        next_seq.bit_cnt = seq.bit_cnt + 4'h1;
        case (seq.phase)
            host_port_pkg::SEQ_CTRL: begin
                // Address is known one bit early: gives the read time to return
                if (seq.bit_cnt == `HP_ADDR_DONE && word[`HP_RW_EARLY] == `HP_RW_READ) begin
                    next_xfer.rd_addr   = early[`HP_ADDR_W-1:0];
                    next_xfer.rd_toggle = ~xfer.rd_toggle;
                end
                if (seq.bit_cnt == `HP_CTRL_LAST) begin
                    next_seq.is_read = word[`HP_CTRL_RW];
                    next_seq.burst   = word[`HP_CTRL_BURST];
                    next_seq.addr    = field[`HP_ADDR_W-1:0];
                    next_seq.phase   = host_port_pkg::SEQ_DATA;
                    next_seq.bit_cnt = 4'h0;
                end
            end
            host_port_pkg::SEQ_DATA: begin
                if (seq.bit_cnt == `HP_PREFETCH_AT && seq.is_read && seq.burst) begin
                    next_xfer.rd_addr   = seq.addr + `HP_ADDR_ONE;
                    next_xfer.rd_toggle = ~xfer.rd_toggle;
                end
                if (seq.bit_cnt == `HP_DATA_LAST) begin
                    next_seq.bit_cnt = 4'h0;
                    if (!seq.is_read) begin
                        next_xfer.wr_addr   = seq.addr;
                        next_xfer.wr_data   = host_port_pkg::order_byte(word[7:0], msb_first);
                        next_xfer.wr_toggle = ~xfer.wr_toggle;
                    end
                    if (seq.burst) begin
                        next_seq.addr = seq.addr + `HP_ADDR_ONE;
                    end else begin
                        next_seq.phase = host_port_pkg::SEQ_CTRL;
                    end
                end
            end
            default: begin
                next_seq.phase = host_port_pkg::SEQ_CTRL;
            end
        endcase
        next_tx      = tx;
        next_tx.oe_n = 1'b0;
        if (seq.phase == host_port_pkg::SEQ_DATA && seq.bit_cnt == 4'h0 && seq.is_read) begin
            {next_tx.out, next_tx.shift} = host_port_pkg::order_byte(rd_word, msb_first);
        end else begin
            {next_tx.out, next_tx.shift} = {tx.shift, 1'b0};
        end
    end

    always_ff @(posedge sample_clk or posedge seq_clear) begin
        if (seq_clear) begin
            seq <= '0;
        end else begin
            seq <= next_seq;
        end
    end

    always_ff @(posedge sample_clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer <= '0;
        end else begin
            xfer <= next_xfer;
        end
    end

    // Output changes on the edge opposite to sampling
    always_ff @(negedge sample_clk or posedge seq_clear) begin
        if (seq_clear) begin
            tx <= 9'h001;
        end else begin
            tx <= next_tx;
        end
    end

    assign serial_data_out  = tx.out;
    assign serial_data_oe_n = tx.oe_n;
    assign rd_addr          = xfer.rd_addr;
    assign rd_toggle        = xfer.rd_toggle;
    assign wr_addr          = xfer.wr_addr;
    assign wr_data          = xfer.wr_data;
    assign wr_toggle        = xfer.wr_toggle;

endmodule // spi_link_engine

`default_nettype wire

//--- host_port_parallel_spi_asserts.sv
`default_nettype none
module host_port_parallel_spi_asserts #(
    parameter int IRQ_COUNT = 8
) (
    // Watched ports
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    input wire logic                 serial_port_select,
    input wire logic                 address_top_line,
    input wire logic [8:0]           address_low,
    input wire logic                 chip_select_n,
    input wire logic                 read_strobe_n,
    input wire logic [7:0]           data_in,
    input wire logic [7:0]           data_oe_n,
    input wire logic                 serial_data_oe_n,
    input wire logic [IRQ_COUNT-1:0] irq_pending,
    input wire logic [IRQ_COUNT-1:0] irq_mask,
    input wire logic                 interrupt_out_n,
    input wire logic                 interrupt_oe_n,
    input wire logic [9:0]           reg_addr,
    input wire logic [7:0]           reg_wr_data,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // ----------
    // Port rules
    // ----------
    property p_irq; 1'b1 |=> interrupt_oe_n == !$past(|(irq_pending & ~irq_mask)); endproperty
    a_irq: assert property (p_irq) else $error("interrupt enable wrong");
    property p_pin; interrupt_out_n == 1'b0; endproperty
    a_pin: assert property (p_pin) else $error("interrupt pin not open drain");
    property p_wr; reg_wr |=> !reg_wr; endproperty
    a_wr: assert property (p_wr) else $error("write pulse too long");
    property p_wrt; reg_wr && !serial_port_select |-> {reg_addr, reg_wr_data} ==
        $past({address_top_line, address_low, data_in}, 5); endproperty
    a_wrt: assert property (p_wrt) else $error("write target wrong");
    property p_rdt; reg_rd && !serial_port_select |->
        reg_addr == $past({address_top_line, address_low}, 3); endproperty
    a_rdt: assert property (p_rdt) else $error("read index wrong");
    property p_drv; $fell(data_oe_n[0]) |-> $past(!chip_select_n && !read_strobe_n, 3); endproperty
    a_drv: assert property (p_drv) else $error("bus driven without read");
    property p_rel; chip_select_n [*6] |-> data_oe_n == 8'hff; endproperty
    a_rel: assert property (p_rel) else $error("bus not released");
    property p_idle; (!serial_port_select && chip_select_n) [*8] |-> !reg_wr && !reg_rd; endproperty
    a_idle: assert property (p_idle) else $error("access without select");
    property p_miso; chip_select_n |-> serial_data_oe_n; endproperty
    a_miso: assert property (p_miso) else $error("serial out driven while idle");
    c_wr: cover property (reg_wr);
    c_rd: cover property (reg_rd);
    c_irq: cover property (!interrupt_oe_n);
endmodule // host_port_parallel_spi_asserts

bind host_port_parallel_spi host_port_parallel_spi_asserts #(.IRQ_COUNT(IRQ_COUNT)) chk_i (
    .sys_clk, .rst_n, .serial_port_select, .address_top_line, .address_low, .chip_select_n,
    .read_strobe_n, .data_in, .data_oe_n, .serial_data_oe_n, .irq_pending, .irq_mask,
    .interrupt_out_n, .interrupt_oe_n, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd);
`default_nettype wire

//--- spi_master_model.sv
`default_nettype none
module spi_master_model (
    // Link pins
    output var logic  serial_clock,
    output var logic  chip_select_n,
    output var logic  serial_data_in,
    input  wire logic serial_data_out,
    input  wire logic serial_data_oe_n,
    // Straps
    input  wire logic clock_polarity,
    input  wire logic clock_phase
);
    timeunit 1ns;
    timeprecision 1ps;
    logic miso;
    // Released line shows the inverse of the last bit, never a stale copy
    assign miso = serial_data_oe_n ? ~serial_data_in : serial_data_out;
    initial begin
        {serial_clock, chip_select_n, serial_data_in} = 3'b010;
    end
    // Clock only runs inside frames; odd offset keeps it off the system edges
    task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = '0;
        serial_clock = clock_polarity;
        serial_data_in = tx[0];
        #24.7 chip_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (!clock_phase) serial_data_in = tx[i];
            #24 serial_clock = ~serial_clock;
            if (clock_phase) serial_data_in = tx[i];
            else rx[i] = miso;
            #24 serial_clock = ~serial_clock;
            if (clock_phase) rx[i] = miso;
        end
        #24 chip_select_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #24;
    endtask
endmodule // spi_master_model
`default_nettype wire

//--- host_port_parallel_spi_tb_top.sv
`default_nettype none
module host_port_parallel_spi_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst_n, serial_port_select, bus_style_select, address_top_line;
    logic [8:0]  address_low;
    logic        par_cs_n, spi_cs_n, read_strobe_n, write_strobe_n;
    logic [7:0]  data_in, data_out, data_oe_n, reg_wr_data, reg_rd_data, wd;
    logic        serial_clock, serial_data_in, serial_data_out, serial_data_oe_n;
    logic [7:0]  irq_pending, irq_mask;
    logic        interrupt_out_n, interrupt_oe_n, reg_wr, reg_rd;
    logic [9:0]  reg_addr, wa;
    logic [63:0] rx;
    wire         chip_select_n = serial_port_select ? spi_cs_n : par_cs_n;
    int          failures = 0, cmp_count = 0, wn = 0;

    host_port_parallel_spi #(.IRQ_COUNT(8)) dut (.sys_clk, .rst_n, .serial_port_select,
        .bus_style_select, .address_top_line, .address_low, .chip_select_n, .read_strobe_n,
        .write_strobe_n, .data_in, .data_out, .data_oe_n, .serial_clock, .serial_data_in,
        .serial_data_out, .serial_data_oe_n, .irq_pending, .irq_mask, .interrupt_out_n,
        .interrupt_oe_n, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data);
    spi_master_model link (.serial_clock, .chip_select_n(spi_cs_n), .serial_data_in,
        .serial_data_out, .serial_data_oe_n, .clock_polarity(data_in[7]),
        .clock_phase(data_in[6]));

    function automatic logic [7:0] rdv(input logic [9:0] a);
        rdv = a[7:0] ^ {a[9:8], 6'h2a};
    endfunction
    assign reg_rd_data = rdv(reg_addr);
    always @(posedge sys_clk) begin
        if (reg_wr === 1'b1) begin
            wa <= reg_addr;
            wd <= reg_wr_data;
            wn <= wn + 1;
        end
    end
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // -------
    // Helpers
    // -------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Stream order: bit 0 leaves first
    function automatic logic [15:0] ctl(input logic r, input logic b, input logic [9:0] a,
                                        input logic msb);
        logic [13:0] f;
        f = {4'h0, a};
        ctl = {b, 14'h0, r};
        for (int i = 0; i < 14; i++) ctl[1+i] = msb ? f[13-i] : f[i];
    endfunction
    function automatic logic [7:0] ord(input logic [7:0] d, input logic msb);
        for (int i = 0; i < 8; i++) ord[i] = msb ? d[7-i] : d[i];
    endfunction
    task automatic par(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic cs);
        int n0;
        n0 = wn;
        @(posedge sys_clk);
        par_cs_n <= cs;
        {address_top_line, address_low} <= a;
        data_in <= d;
        write_strobe_n <= bus_style_select ? !wr : 1'b1;
        @(posedge sys_clk);
        if (bus_style_select || !wr) read_strobe_n <= 1'b0;
        else write_strobe_n <= 1'b0;
        cyc(8);
        if (!wr) chk(data_oe_n, cs ? 8'hff : 8'h00);
        if (!wr && !cs) chk(data_out, rdv(a));
        read_strobe_n <= 1'b1;
        if (!bus_style_select) write_strobe_n <= 1'b1;
        cyc(8);
        par_cs_n <= 1'b1;
        cyc(6);
        chk(data_oe_n, 8'hff);
        if (wr && !cs) chk({wa, wd}, {a, d});
        if (cs) chk(24'(wn - n0), 24'd0);
    endtask
    task automatic mode(input logic [2:0] m);
        @(posedge sys_clk);
        serial_port_select <= 1'b1;
        data_in <= {m, 5'h00};
        cyc(6);
    endtask
    // ---------
    // Scenarios
    // ---------
    task automatic t_par();
        for (int s = 0; s < 2; s++) begin
            @(posedge sys_clk);
            bus_style_select <= s[0];
            write_strobe_n <= 1'b1;
            cyc(4);
            par(1'b1, {1'b1, 8'h00, s[0]}, 8'ha5 ^ s[7:0], 1'b0);
            par(1'b0, 10'h155, 8'h00, 1'b0);
            par(1'b1, 10'h0aa, 8'h3c, 1'b1);
            par(1'b0, 10'h2aa, 8'h00, 1'b1);
        end
        $display("test parallel done");
    endtask
    task automatic t_irq();
        @(posedge sys_clk);
        irq_pending <= 8'h11;
        irq_mask <= 8'h11;
        cyc(4);
        chk(interrupt_oe_n, 1'b1);
        irq_mask <= 8'h01;
        cyc(4);
        chk({interrupt_oe_n, interrupt_out_n}, 2'b00);
        irq_pending <= 8'h01;
        cyc(4);
        chk(interrupt_oe_n, 1'b1);
        $display("test interrupt done");
    endtask
    task automatic t_spi_modes();
        logic [9:0] a;
        logic [7:0] d;
        for (int m = 0; m < 8; m++) begin
            a = {m[2:0], 7'h4b};
            d = 8'h96 ^ m[7:0];
            mode(m[2:0]);
            link.frame({40'h0, ord(d, m[0]), ctl(1'b0, 1'b0, a, m[0])}, 24, rx);
            chk({wa, wd}, {a, d});
            link.frame({40'h0, 8'h00, ctl(1'b1, 1'b0, ~a, m[0])}, 24, rx);
            chk(ord(rx[23:16], m[0]), rdv(~a));
        end
        $display("test serial modes done");
    endtask
    task automatic t_spi_burst();
        int n0;
        for (int p = 0; p < 2; p++) begin
            mode({1'b0, p[0], 1'b1});
            n0 = wn;
            link.frame({32'h0, ord(8'h5a, 1'b1), ord(8'h3c, 1'b1),
                        ctl(1'b0, 1'b1, 10'h1fe, 1'b1)}, 32, rx);
            chk({wa, wd, 6'(wn - n0)}, {10'h1ff, 8'h5a, 6'd2});
            n0 = wn;
            link.frame({16'h0, ord(8'h66, 1'b1), ctl(1'b0, 1'b0, 10'h0c3, 1'b1),
                        ord(8'h99, 1'b1), ctl(1'b0, 1'b0, 10'h3c0, 1'b1)}, 48, rx);
            chk({wa, wd, 6'(wn - n0)}, {10'h0c3, 8'h66, 6'd2});
            n0 = wn;
            link.frame({36'h0, 4'h5, ord(8'h77, 1'b1), ctl(1'b0, 1'b1, 10'h050, 1'b1)}, 28, rx);
            link.frame({40'h0, ord(8'h81, 1'b1), ctl(1'b0, 1'b1, 10'h2f0, 1'b1)}, 24, rx);
            chk({wa, wd, 6'(wn - n0)}, {10'h2f0, 8'h81, 6'd2});
            link.frame({48'h0, ctl(1'b1, 1'b1, 10'h0ff, 1'b1)}, 32, rx);
            chk(rx[31:16], {ord(rdv(10'h100), 1'b1), ord(rdv(10'h0ff), 1'b1)});
        end
        $display("test serial burst done");
    endtask
    initial begin
        rst_n = 1'b0;
        {serial_port_select, bus_style_select, address_top_line, address_low, data_in} = '0;
        {par_cs_n, read_strobe_n, write_strobe_n, irq_pending, irq_mask} = 19'h7_0000;
        cyc(10);
        rst_n <= 1'b1;
        cyc(8);
        t_par();
        t_irq();
        t_spi_modes();
        t_spi_burst();
        end_sim();
    end
endmodule // host_port_parallel_spi_tb_top
`default_nettype wire
